/* File: rtl/fcpp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fcpp_host
    import fcpp_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic CE_N_OUT,
    output logic COMMAND_LATCH_OUT,
    output logic ADDRESS_LATCH_OUT,
    output logic WE_N_OUT,
    output logic RE_N_OUT,
    output logic WP_N_OUT,
    output logic [15:0] IO_OUT,
    output logic IO_OE_OUT,
    input wire logic [15:0] IO_IN,
    input wire logic BUSY_N_IN
);
    // APB answer flops
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    // Software visible state
    logic [31:0] ctrl_q;
    logic wp_release_q;
    logic wide_q;
    logic refused_q;
    logic [15:0] rdata_q;
    // Pin drivers
    logic ce_n_q;
    logic cle_q;
    logic ale_q;
    logic we_n_q;
    logic re_n_q;
    logic [15:0] io_q;
    logic io_oe_q;
    // Cycle engine
    fcpp_state_type state_q;
    logic [7:0] cnt_q;
    logic [2:0] kind_q;
    // Sequence tracker
    fcpp_seq_type seq_q;
    logic ptr_wait_q;
    logic [2:0] addr_cnt_q;
    logic [9:0] data_cnt_q;
    logic [15:0] row_q;
    logic [15:0] last_row_q;
    logic [1:0] prog_cnt_q;

    // Bus decode
    wire logic access = PSEL_IN & PENABLE_IN & ~pready_q;
    wire logic done = PSEL_IN & PENABLE_IN & pready_q;
    wire logic hit_ctrl = (PADDR_IN == OFS_CTRL);
    wire logic hit_cfg = (PADDR_IN == OFS_CFG);
    wire logic hit_stat = (PADDR_IN == OFS_STATUS);
    wire logic hit_rdata = (PADDR_IN == OFS_RDATA);
    wire logic mapped = hit_ctrl | hit_cfg | hit_stat | hit_rdata;
    wire logic wr_done = done & PWRITE_IN & ~pslverr_q;
    wire logic go_wr = wr_done & hit_ctrl;
    wire logic cfg_wr = wr_done & hit_cfg;
    wire logic clr_wr = wr_done & hit_stat & PWDATA_IN[STAT_REFUSED_BIT];

    // Requested bus cycle
    wire logic [2:0] req_kind = PWDATA_IN[CTRL_KIND_LSB +: 3];
    wire logic [7:0] req_code = PWDATA_IN[7:0];
    wire logic req_cmd = (req_kind == KIND_CMD);
    wire logic req_addr = (req_kind == KIND_ADDR);
    wire logic req_din = (req_kind == KIND_DIN);
    wire logic req_dout = (req_kind == KIND_DOUT);
    wire logic req_known = (req_kind <= KIND_DESEL);
    wire logic [9:0] max_items = wide_q ? MAX_ITEMS_WORD : MAX_ITEMS_BYTE;
    wire logic same_row = (row_q == last_row_q);
    wire logic is_ptr = (req_code == CODE_PTR_FIRST) | (req_code == CODE_PTR_SECOND)
        | (req_code == CODE_PTR_SPARE);
    wire logic is_setup = (req_code == CODE_PROG_SETUP) | (req_code == CODE_COPY_SETUP);

    // Refusals, checked before anything reaches the pins
    // confirm needs setup
    wire logic bad_confirm = req_cmd & (req_code == CODE_CONFIRM) & (seq_q != SEQ_PROG);
    wire logic bad_erase = req_cmd & (req_code == CODE_ERASE_CONFIRM) & (seq_q != SEQ_ERASE);
    wire logic bad_partial = req_cmd & (req_code == CODE_CONFIRM) & same_row
        & (prog_cnt_q == MAX_PARTIAL);
    wire logic bad_read = req_dout & ptr_wait_q;
    wire logic bad_load = req_din & ((seq_q != SEQ_PROG) | (addr_cnt_q < PROG_ADDR_CYCLES)
        | (data_cnt_q == max_items));
    wire logic refuse = (state_q != ST_IDLE) | ~req_known | bad_confirm | bad_erase
        | bad_partial | bad_read | bad_load;
    wire logic accept = go_wr & ~refuse;
    wire logic take_cmd = accept & req_cmd;
    wire logic take_addr = accept & req_addr;
    wire logic take_confirm = take_cmd & (req_code == CODE_CONFIRM);
    wire logic take_erase = take_cmd & (req_code == CODE_ERASE_CONFIRM);

    // Read mux for the registered answer
    wire logic [31:0] stat_word = {26'h0, prog_cnt_q, 1'b0, refused_q, BUSY_N_IN,
        state_q != ST_IDLE};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_q
        : hit_cfg ? {30'h0, wide_q, wp_release_q}
        : hit_stat ? stat_word
        : hit_rdata ? {16'h0, rdata_q}
        : 32'h0;
    wire logic cnt_zero = (cnt_q == 8'h0);

    // APB slave: one wait state, unmapped addresses answer with an error
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else if (CLK_EN_IN)
        begin
            pready_q <= access;
            pslverr_q <= access & ~mapped;
            prdata_q <= access ? rd_mux : prdata_q;
        end
    end

    // Control word, configuration and sticky refusal flag
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            ctrl_q <= 32'h0;
            wp_release_q <= 1'b0;
            wide_q <= 1'b0;
            refused_q <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            if (go_wr)
            begin
                ctrl_q <= PWDATA_IN;
            end
            if (cfg_wr)
            begin
                wp_release_q <= PWDATA_IN[CFG_WP_RELEASE_BIT];
                wide_q <= PWDATA_IN[CFG_WIDE_BIT];
            end
            // New refusal beats a clear in the same cycle
            refused_q <= (go_wr & refuse) | (refused_q & ~clr_wr);
        end
    end

    // Command sequence tracker mirrors what the device has been told
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            seq_q <= SEQ_NONE;
            ptr_wait_q <= 1'b0;
            addr_cnt_q <= 3'h0;
            data_cnt_q <= 10'h0;
            row_q <= 16'h0;
        end
        else if (CLK_EN_IN)
        begin
            if (take_cmd)
            begin
                seq_q <= is_setup ? SEQ_PROG
                    : (req_code == CODE_ERASE_SETUP) ? SEQ_ERASE : SEQ_NONE;
                ptr_wait_q <= is_ptr;
                addr_cnt_q <= 3'h0;
                data_cnt_q <= 10'h0;
            end
            else if (take_addr)
            begin
                // Saturate so extra address cycles cannot wrap the count
                addr_cnt_q <= (addr_cnt_q == 3'h7) ? addr_cnt_q : addr_cnt_q + 3'h1;
                ptr_wait_q <= ptr_wait_q & (addr_cnt_q + 3'h1 < PTR_ADDR_CYCLES);
                // Row bytes are the second and third address cycles
                row_q[7:0] <= (addr_cnt_q == 3'h1) ? req_code : row_q[7:0];
                row_q[15:8] <= (addr_cnt_q == 3'h2) ? req_code : row_q[15:8];
            end
            else if (accept & req_din)
            begin
                data_cnt_q <= data_cnt_q + 10'h1;
            end
        end
    end

    // Partial program bookkeeping for the last programmed page
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            last_row_q <= 16'h0;
            prog_cnt_q <= 2'h0;
        end
        else if (CLK_EN_IN)
        begin
            if (take_confirm)
            begin
                last_row_q <= row_q;
                prog_cnt_q <= same_row ? prog_cnt_q + 2'h1 : 2'h1;
            end
            else if (take_erase)
            begin
                // Erase of any block frees the tracked page; coarse but safe
                prog_cnt_q <= 2'h0;
            end
        end
    end

    // Pin cycle engine: setup, strobe low, strobe high, then idle
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h0;
            kind_q <= KIND_CMD;
            ce_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            io_q <= 16'h0;
            io_oe_q <= 1'b0;
            rdata_q <= 16'h0;
        end
        else if (CLK_EN_IN)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        kind_q <= req_kind;
                        cle_q <= req_cmd;
                        ale_q <= req_addr;
                        io_q <= (req_cmd | req_addr) ? {8'h0, req_code} : PWDATA_IN[15:0];
                        io_oe_q <= req_cmd | req_addr | req_din;
                        // chip select high ends row read
                        ce_n_q <= (req_kind == KIND_DESEL);
                        cnt_q <= (req_kind == KIND_DESEL) ? DESELECT_CYC : BUSY_SETTLE_CYC;
                        state_q <= (req_kind == KIND_DESEL) ? ST_DESEL
                            : (req_kind == KIND_WAIT) ? ST_SETTLE : ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    // Latch lines and data have had one cycle to settle
                    we_n_q <= (kind_q == KIND_DOUT);
                    re_n_q <= (kind_q != KIND_DOUT);
                    cnt_q <= STROBE_LOW_CYC - 8'h1;
                    state_q <= ST_LOW;
                end
                ST_LOW:
                begin
                    if (cnt_zero)
                    begin
                        // Input sampled just before read strobe rises
                        if (kind_q == KIND_DOUT)
                        begin
                            rdata_q <= wide_q ? IO_IN : {8'h0, IO_IN[7:0]};
                        end
                        we_n_q <= 1'b1;
                        re_n_q <= 1'b1;
                        cnt_q <= STROBE_HIGH_CYC - 8'h1;
                        state_q <= ST_HIGH;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                ST_HIGH:
                begin
                    if (cnt_zero)
                    begin
                        cle_q <= 1'b0;
                        ale_q <= 1'b0;
                        io_oe_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                ST_SETTLE, ST_DESEL:
                begin
                    // Busy may fall a little after the last strobe; deselect just holds
                    // new block needs new read
                    if (cnt_zero)
                    begin
                        state_q <= (state_q == ST_SETTLE) ? ST_READY : ST_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                ST_READY:
                begin
                    // No timeout here; software may reset if the device hangs
                    if (BUSY_N_IN)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Output flops straight to pins
    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign CE_N_OUT = ce_n_q;
    assign COMMAND_LATCH_OUT = cle_q;
    assign ADDRESS_LATCH_OUT = ale_q;
    assign WE_N_OUT = we_n_q;
    assign RE_N_OUT = re_n_q;
    assign WP_N_OUT = wp_release_q;
    assign IO_OUT = io_q;
    assign IO_OE_OUT = io_oe_q;
endmodule // fcpp_host
`default_nettype wire

/* File: shared/fcpp_pkg.sv */
// Contract
// - Command codes on low byte, latch high
// - Program 80h-10h, copy 00h-8Ah-10h, erase 60h-D0h
// - Host gives three address cycles after pointer
// - Next-page reads stay inside one block
// - Chip select high beyond deselect time ends
// - At most three partial programs per page; the host counts only the last programmed page
// - Setup, four addresses, data, then confirm 10h
package fcpp_pkg;
    // Command codes
    localparam logic [7:0] CODE_PTR_FIRST = 8'h00;
    localparam logic [7:0] CODE_PTR_SECOND = 8'h01;
    localparam logic [7:0] CODE_PTR_SPARE = 8'h50;
    localparam logic [7:0] CODE_PROG_SETUP = 8'h80;
    localparam logic [7:0] CODE_COPY_SETUP = 8'h8a;
    localparam logic [7:0] CODE_CONFIRM = 8'h10;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CODE_ERASE_CONFIRM = 8'hd0;
    localparam logic [7:0] CODE_RESET = 8'hff;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CFG = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_RDATA = 12'h00c;
    // Field positions
    localparam int CTRL_KIND_LSB = 16;
    localparam int CFG_WP_RELEASE_BIT = 0;
    localparam int CFG_WIDE_BIT = 1;
    localparam int STAT_ENGINE_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_PCNT_LSB = 4;
    // Bus cycle kinds carried in the control word
    localparam logic [2:0] KIND_CMD = 3'h0;
    localparam logic [2:0] KIND_ADDR = 3'h1;
    localparam logic [2:0] KIND_DIN = 3'h2;
    localparam logic [2:0] KIND_DOUT = 3'h3;
    localparam logic [2:0] KIND_WAIT = 3'h4;
    localparam logic [2:0] KIND_DESEL = 3'h5;
    // Sequence limits
    localparam logic [2:0] PTR_ADDR_CYCLES = 3'h3;
    localparam logic [2:0] PROG_ADDR_CYCLES = 3'h4;
    localparam logic [9:0] MAX_ITEMS_BYTE = 10'h210;
    localparam logic [9:0] MAX_ITEMS_WORD = 10'h108;
    localparam logic [1:0] MAX_PARTIAL = 2'h3;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STROBE_LOW_NS = 50;
    localparam int STROBE_HIGH_NS = 50;
    localparam int BUSY_SETTLE_NS = 100;
    localparam int DESELECT_TIME_NS = 100;
    localparam logic [7:0] STROBE_LOW_CYC =
        8'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] STROBE_HIGH_CYC =
        8'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] BUSY_SETTLE_CYC =
        8'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // One extra cycle so chip select stays high strictly longer than the limit
    localparam logic [7:0] DESELECT_CYC = 8'((DESELECT_TIME_NS / CLK_PERIOD_NS) + 1);
    // Engine states and sequence tracking
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_SETTLE, ST_READY,
        ST_DESEL} fcpp_state_type;
    typedef enum logic [1:0] {SEQ_NONE, SEQ_PROG, SEQ_ERASE} fcpp_seq_type;
endpackage

/* File: tb/fcpp_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fcpp_host_asserts
    import fcpp_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic CE_N_OUT,
    input wire logic COMMAND_LATCH_OUT,
    input wire logic ADDRESS_LATCH_OUT,
    input wire logic WE_N_OUT,
    input wire logic RE_N_OUT,
    input wire logic WP_N_OUT,
    input wire logic [15:0] IO_OUT,
    input wire logic IO_OE_OUT
);
    // Address hits one of the four registers
    wire logic mapped = PADDR_IN inside {OFS_CTRL, OFS_CFG, OFS_STATUS, OFS_RDATA};
    default clocking @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);
    chk_apb_wait: assert property ($rose(PENABLE_IN) && PSEL_IN |-> !PREADY_OUT ##1 PREADY_OUT)
        else $error("ready not after one wait state");
    chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    chk_err_decode: assert property (PREADY_OUT |-> PSLVERR_OUT == !mapped)
        else $error("error response does not match address");
    chk_latch_excl: assert property (
        !(COMMAND_LATCH_OUT && ADDRESS_LATCH_OUT) && (WE_N_OUT || RE_N_OUT))
        else $error("latches or strobes overlap");
    chk_we_pulse: assert property (
        $fell(WE_N_OUT) |-> (!CE_N_OUT && IO_OE_OUT && !WE_N_OUT)[*2] ##1 WE_N_OUT)
        else $error("write strobe shape wrong");
    chk_cmd_byte: assert property (
        !WE_N_OUT && (COMMAND_LATCH_OUT || ADDRESS_LATCH_OUT)
        |-> IO_OUT[15:8] == 8'h00 && $stable(IO_OUT))
        else $error("command or address byte unstable");
    chk_desel_hold: assert property ($rose(CE_N_OUT) |-> CE_N_OUT[*4])
        else $error("deselect too short");
    chk_reset_pins: assert property (disable iff (1'b0) RST_IN |=> CE_N_OUT && WE_N_OUT && RE_N_OUT && !IO_OE_OUT && !WP_N_OUT)
        else $error("pins not idle in reset");
    cover property (PREADY_OUT && PSLVERR_OUT);
    cover property ($rose(CE_N_OUT));
    cover property (!WE_N_OUT && COMMAND_LATCH_OUT);
endmodule // fcpp_host_asserts
bind fcpp_host fcpp_host_asserts chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .CE_N_OUT(CE_N_OUT), .COMMAND_LATCH_OUT(COMMAND_LATCH_OUT),
    .ADDRESS_LATCH_OUT(ADDRESS_LATCH_OUT), .WE_N_OUT(WE_N_OUT), .RE_N_OUT(RE_N_OUT),
    .WP_N_OUT(WP_N_OUT), .IO_OUT(IO_OUT), .IO_OE_OUT(IO_OE_OUT));
`default_nettype wire

/* File: tb/fcpp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcpp_flash_model
(
    input wire logic ce_n_in,
    input wire logic cle_in,
    input wire logic ale_in,
    input wire logic we_n_in,
    input wire logic re_n_in,
    input wire logic wp_n_in,
    input wire logic [15:0] io_in,
    output logic [15:0] io_out,
    output var logic busy_n_out
);
    logic [1:0] ptr_q = 2'h0; // Pointer: first half, second half, spare
    logic [1:0] cur_q = 2'h0; // Area of the buffered page
    logic [7:0] col_q = 8'h00; // Next column
    logic [2:0] acnt_q = 3'h0; // Address cycles seen
    logic stat_q = 1'b0; // Reads return status
    logic prog_q = 1'b0; // Program setup seen
    logic ers_q = 1'b0; // Erase setup seen
    int busy_ns = 0;
    event go;
    initial
    begin
        busy_n_out = 1'b1;
        io_out = 16'h0000;
    end
    // Busy window; a retrigger while busy is lost, fine for these tests
    always @(go)
    begin
        busy_n_out = 1'b0;
        #(busy_ns) busy_n_out = 1'b1;
    end
    // data-in strobes carry no command and are ignored
    always @(posedge we_n_in)
    begin
        if (!ce_n_in && cle_in && (busy_n_out || io_in[7:0] inside {8'h70, 8'hff}))
        begin
            case (io_in[7:0])
                8'h00, 8'h01, 8'h50:
                begin
                    ptr_q = io_in[6] ? 2'h2 : {1'b0, io_in[0]};
                    {acnt_q, stat_q} = 4'h0;
                end
                8'h80: {prog_q, acnt_q, stat_q} = {wp_n_in, 4'h0};
                8'h60: {ers_q, acnt_q, stat_q} = {wp_n_in, 4'h0};
                8'h10, 8'hd0:
                    if (io_in[7] ? ers_q : prog_q)
                    begin
                        {prog_q, ers_q, stat_q} = 3'b001;
                        ptr_q = (ptr_q == 2'h1) ? 2'h0 : ptr_q;
                        busy_ns = 400;
                        -> go;
                    end
                8'h70: stat_q = 1'b1;
                8'hff:
                begin
                    {ptr_q, prog_q, ers_q, stat_q} = 5'h00;
                    busy_ns = 100;
                    -> go;
                end
                default: ;
            endcase
        end
        // third address of a read loads the page
        else if (!ce_n_in && ale_in && busy_n_out)
        begin
            if (acnt_q == 3'h0)
                col_q = (ptr_q == 2'h2) ? {4'h0, io_in[3:0]} : io_in[7:0];
            acnt_q = acnt_q + 3'h1;
            if (acnt_q == 3'h3 && !prog_q && !ers_q)
            begin
                cur_q = ptr_q;
                ptr_q = (ptr_q == 2'h1) ? 2'h0 : ptr_q;
                busy_ns = 200;
                -> go;
            end
        end
    end
    // item or status on the read strobe
    // no bit ever fails to program here, so the fail bit stays 0
    always @(negedge re_n_in)
        if (!ce_n_in)
            io_out = stat_q ? {8'h00, wp_n_in, busy_n_out, 6'h00} : {6'h00, cur_q, col_q};
    // Released bus shows the inverse so a stale value never passes
    // a column wrap while selected loads the next page
    always @(posedge re_n_in)
    begin
        #5 io_out = ~io_out;
        col_q = col_q + {7'h0, !stat_q};
        if (col_q == 8'h00 && !stat_q && !ce_n_in)
        begin
            busy_ns = 200;
            -> go;
        end
    end
endmodule // fcpp_flash_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import fcpp_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic rdy, err, ce_n, cle, ale, we_n, re_n, wp_n, oe, busy_n;
    logic [15:0] io_o, io_m;
    // Shared data bus: host wins while it drives
    wire logic [15:0] bus = oe ? io_o : io_m;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    fcpp_host uut (.MCLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
        .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .CE_N_OUT(ce_n),
        .COMMAND_LATCH_OUT(cle), .ADDRESS_LATCH_OUT(ale), .WE_N_OUT(we_n), .RE_N_OUT(re_n),
        .WP_N_OUT(wp_n), .IO_OUT(io_o), .IO_OE_OUT(oe), .IO_IN(bus), .BUSY_N_IN(busy_n));
    fcpp_flash_model flash (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
        .re_n_in(re_n), .wp_n_in(wp_n), .io_in(bus), .io_out(io_m), .busy_n_out(busy_n));
    task automatic finish_test;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, far above the roughly one thousand cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // One APB transfer, entered just after an edge; one idle edge at the end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ctrl(input logic [2:0] k, input logic [15:0] v);
        logic [31:0] q;
        logic e;
        apb(1'b1, OFS_CTRL, {13'h0, k, v}, q, e);
        // Engine must be idle before the next order
        do
            apb(1'b0, OFS_STATUS, 32'h0, q, e);
        while (q[STAT_ENGINE_BIT] !== 1'b0);
    endtask
    task automatic dout(input logic [15:0] exp, input string nm);
        logic [31:0] q;
        logic e;
        ctrl(KIND_DOUT, 16'h0);
        apb(1'b0, OFS_RDATA, 32'h0, q, e);
        chk(nm, {16'h0, exp}, q);
    endtask
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        chk("pins", 7'b1110000, {ce_n, we_n, re_n, wp_n, cle, ale, oe});
        apb(1'b0, OFS_STATUS, 32'h0, q, e);
        chk("status", 32'h2, q);
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
    endtask
    task automatic t_ptr;
        logic [7:0] code [3] = '{8'h00, 8'h01, 8'h50};
        logic [15:0] base [3] = '{16'h035, 16'h135, 16'h005};
        logic [31:0] q;
        logic e;
        apb(1'b1, OFS_CFG, 32'h3, q, e);
        foreach (code[i])
        begin
            // Spare reads run in byte mode so the narrow read path is seen too
            if (i == 2)
                apb(1'b1, OFS_CFG, 32'h1, q, e);
            ctrl(KIND_CMD, {8'h0, code[i]});
            ctrl(KIND_ADDR, 16'h35);
            ctrl(KIND_ADDR, 16'h01);
            ctrl(KIND_ADDR, 16'h00);
            ctrl(KIND_WAIT, 16'h0);
            dout(base[i], "first item");
            dout(base[i] + 16'h1, "next item");
        end
    endtask
    task automatic t_prog;
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 4; i++)
        begin
            ctrl(KIND_CMD, {8'h0, CODE_PROG_SETUP});
            repeat (4) ctrl(KIND_ADDR, 16'h02);
            ctrl(KIND_DIN, 16'ha5);
            ctrl(KIND_CMD, {8'h0, CODE_CONFIRM});
            ctrl(KIND_WAIT, 16'h0);
            apb(1'b0, OFS_STATUS, 32'h0, q, e);
            chk("refused", i == 3, q[STAT_REFUSED_BIT]);
            chk("count", (i < 3) ? i + 1 : 3, q[5:4]);
            // Status must stand after a program, before any new command
            if (i == 2)
            begin
                dout(16'hc0, "status");
                dout(16'hc0, "status again");
            end
        end
        apb(1'b1, OFS_STATUS, 32'h4, q, e);
        ctrl(KIND_CMD, {8'h0, CODE_ERASE_SETUP});
        ctrl(KIND_ADDR, 16'h02);
        ctrl(KIND_ADDR, 16'h00);
        ctrl(KIND_CMD, {8'h0, CODE_ERASE_CONFIRM});
        ctrl(KIND_WAIT, 16'h0);
        apb(1'b0, OFS_STATUS, 32'h0, q, e);
        chk("erase", 3'b000, {q[5:4], q[STAT_REFUSED_BIT]});
    endtask
    task automatic t_refuse;
        logic [18:0] bad [4] = '{{3'h0, 16'h10}, {3'h0, 16'hd0}, {3'h7, 16'h0}, {3'h3, 16'h0}};
        logic [31:0] q;
        logic e;
        ctrl(KIND_CMD, {8'h0, CODE_PTR_FIRST});
        foreach (bad[i])
        begin
            apb(1'b1, OFS_CTRL, {13'h0, bad[i]}, q, e);
            apb(1'b0, OFS_STATUS, 32'h0, q, e);
            chk("refusal set", 1'b1, q[STAT_REFUSED_BIT]);
            apb(1'b1, OFS_STATUS, 32'h4, q, e);
            apb(1'b0, OFS_STATUS, 32'h0, q, e);
            chk("refusal clear", 1'b0, q[STAT_REFUSED_BIT]);
        end
    endtask
    task automatic t_protect;
        logic [31:0] q;
        logic e;
        apb(1'b1, OFS_CFG, 32'h2, q, e);
        chk("wp pin", 1'b0, wp_n);
        ctrl(KIND_CMD, {8'h0, CODE_PROG_SETUP});
        repeat (4) ctrl(KIND_ADDR, 16'h09);
        ctrl(KIND_DIN, 16'h5a);
        ctrl(KIND_CMD, {8'h0, CODE_CONFIRM});
        ctrl(KIND_WAIT, 16'h0);
        ctrl(KIND_CMD, 16'h70);
        dout(16'h40, "protected status");
        apb(1'b1, OFS_CFG, 32'h3, q, e);
    endtask
    task automatic t_desel;
        ctrl(KIND_DESEL, 16'h0);
        chk("deselected", 1'b1, ce_n);
        ctrl(KIND_CMD, {8'h0, CODE_RESET});
        chk("selected", 1'b0, ce_n);
        ctrl(KIND_WAIT, 16'h0);
        ctrl(KIND_CMD, 16'h70);
        dout(16'hc0, "status after reset code");
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_ptr;
        t_prog;
        t_refuse;
        t_protect;
        t_desel;
        finish_test;
    end
endmodule // tb
`default_nettype wire
